// *** rtl/delay_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
// One-shot: done pulses exactly load_val + 1 cycles after the load cycle; a new load restarts it
module delay_timer #(
   parameter int W = 18
) (
   input  wire logic         clk_sys,
   input  wire logic         reset_n,
   input  wire logic         ce,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   output var  logic         done
);
   logic [W-1:0] cnt_r;
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         cnt_r <= '0;
      end else if (ce) begin
         if (load) begin
            cnt_r <= load_val;
         end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         done <= 1'b0;
      end else if (ce) begin
         done <= !load && (cnt_r == W'(1));
      end
   end
endmodule : delay_timer
`default_nettype wire

// *** rtl/flash_ctl_pkg.sv ***
package flash_ctl_pkg;
   // Register indices on the serial register port
   localparam logic [7:0] REG_CONFIG  = 8'h07;
   localparam logic [7:0] REG_ENABLE  = 8'h0A;
   localparam logic [7:0] REG_FLAGS   = 8'h0B;
   localparam logic [7:0] CONFIG_RST  = 8'h78;
   localparam logic [7:0] ENABLE_RST  = 8'h00;
   localparam logic [7:0] FLAGS_RST   = 8'h00;
   // Config fields
   localparam int CFG_STROBE_POL = 6;
   localparam int CFG_TORCH_POL  = 5;
   localparam int CFG_TX_POL     = 4;
   localparam int CFG_TX_LEVEL   = 3;
   localparam int CFG_INPUT_SUPPLY_MONITOR_EN    = 2;
   // Enable fields
   localparam int EN_NTC    = 7;
   localparam int EN_TX     = 6;
   localparam int EN_STROBE = 5;
   localparam int EN_TORCH  = 4;
   localparam int EN_MODE_L = 0;
   // Flag bits
   localparam int FLG_TX      = 7;
   localparam int FLG_NTC     = 6;
   localparam int FLG_INPUT_SUPPLY_MONITOR    = 5;
   localparam int FLG_UNDERVOLTAGE_LOCKOUT    = 4;
   localparam int FLG_OVP     = 3;
   localparam int FLG_SHORT   = 2;
   localparam int FLG_TSD     = 1;
   localparam int FLG_TIMEOUT = 0;
   localparam logic [7:0] FAULT_MASK = 8'h17;
   // Timing
   localparam int CLK_MHZ       = 250;
   localparam int CNT_W         = 18;
   localparam int T_WR_ON_US    = 554;
   localparam int T_STOP_OFF_US = 32;
   localparam int T_STB_ON_US   = 400;
   localparam int T_STB_OFF_US  = 16;
   localparam int T_TRC_ON_US   = 300;
   localparam int T_TRC_OFF_US  = 16;
   localparam int T_TX_DOWN_US  = 3;
   localparam int T_TX_UP_US    = 2;
   localparam int WR_ON_CYC     = T_WR_ON_US * CLK_MHZ;
   localparam int STOP_OFF_CYC  = T_STOP_OFF_US * CLK_MHZ;
   localparam int STB_ON_CYC    = T_STB_ON_US * CLK_MHZ;
   localparam int STB_OFF_CYC   = T_STB_OFF_US * CLK_MHZ;
   localparam int TRC_ON_CYC    = T_TRC_ON_US * CLK_MHZ;
   localparam int TRC_OFF_CYC   = T_TRC_OFF_US * CLK_MHZ;
   localparam int TX_DOWN_CYC   = T_TX_DOWN_US * CLK_MHZ;
   localparam int TX_UP_CYC     = T_TX_UP_US * CLK_MHZ;
   typedef enum logic [1:0] {MODE_STANDBY, MODE_INDICATOR, MODE_TORCH, MODE_FLASH} op_mode_t;
   typedef enum logic [1:0] {DRV_OFF, DRV_INDICATOR, DRV_TORCH, DRV_FLASH} drive_t;
endpackage : flash_ctl_pkg

// *** rtl/flash_led_mode_flag_control.sv ***
`timescale 1ns/100ps
`default_nettype none
module flash_led_mode_flag_control
   import flash_ctl_pkg::*;
#(
   parameter logic [CNT_W-1:0] WR_ON_CYC_P    = CNT_W'(WR_ON_CYC),
   parameter logic [CNT_W-1:0] STOP_OFF_CYC_P = CNT_W'(STOP_OFF_CYC),
   parameter logic [CNT_W-1:0] STB_ON_CYC_P   = CNT_W'(STB_ON_CYC),
   parameter logic [CNT_W-1:0] TRC_ON_CYC_P   = CNT_W'(TRC_ON_CYC)
) (
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   input  wire logic       ce,
   input  wire logic       reg_wr_stb,
   input  wire logic       reg_rd_stb,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       serial_stop,
   output var  logic [7:0] reg_rdata,
   input  wire logic       strobe_pin,
   input  wire logic       torch_pin,
   input  wire logic       tx_pin,
   input  wire logic       thermistor_check_trip,
   input  wire logic       input_supply_monitor_act,
   input  wire logic       undervoltage_lockout_trip,
   input  wire logic       overvoltage_guard_trip,
   input  wire logic       led_short_det,
   input  wire logic       thermal_shutdown_det,
   input  wire logic       flash_timer_expired,
   output var  logic       led_on,
   output var  logic [1:0] led_drive,
   output var  logic       tx_reduced,
   output var  logic       fault_inhibit,
   output var  logic       mode_locked
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin and monitor synchronisers
   localparam int N_SYNC = 10;
   logic [N_SYNC-1:0] raw_in;
   logic [N_SYNC-1:0] sync_in;
   assign raw_in = {tx_pin, torch_pin, strobe_pin,
                    thermistor_check_trip, input_supply_monitor_act,
                    undervoltage_lockout_trip, overvoltage_guard_trip,
                    led_short_det, thermal_shutdown_det, flash_timer_expired};
   pin_sync #(.W(N_SYNC)) u_sync (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .ce      (ce),
      .d       (raw_in),
      .q       (sync_in)
   );
   logic [6:0] cond_s;
   assign cond_s = sync_in[6:0];

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] config_r;
   logic [7:0] enable_r;
   logic [7:0] flags_r;
   logic       fault_lock_r;
   logic       tx_lock_r;
   logic       wr_seen_r;
   logic       wr_en_acc;
   logic       wr_cfg_acc;
   logic       rd_flags;
   op_mode_t   mode;
   assign wr_en_acc  = reg_wr_stb && (reg_addr == REG_ENABLE);
   assign wr_cfg_acc = reg_wr_stb && (reg_addr == REG_CONFIG);
   assign rd_flags   = reg_rd_stb && (reg_addr == REG_FLAGS);
   assign mode       = op_mode_t'(enable_r[EN_MODE_L +: 2]);

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         config_r <= CONFIG_RST;
      end else if (ce && wr_cfg_acc) begin
         config_r <= reg_wdata;
      end
   end

   // Mode bits hold their value while a transmit lock stands
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         enable_r <= ENABLE_RST;
      end else if (ce && wr_en_acc) begin
         enable_r[7:2] <= reg_wdata[7:2];
         if (!tx_lock_r) begin
            enable_r[1:0] <= reg_wdata[1:0];
         end
      end
   end

   // Delay selection needs to know that the last change came from software
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         wr_seen_r <= 1'b0;
      end else if (ce) begin
         wr_seen_r <= wr_en_acc || wr_cfg_acc;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else if (ce && reg_rd_stb) begin
         unique case (reg_addr)
            REG_CONFIG: reg_rdata <= config_r;
            REG_ENABLE: reg_rdata <= enable_r;
            REG_FLAGS:  reg_rdata <= flags_r;
            default:    reg_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin levels and edges, polarity applied
   logic strobe_act;
   logic torch_act;
   logic tx_act;
   logic tx_prev_r;
   logic tx_rise_ev;
   logic tx_fall_ev;
   assign strobe_act = config_r[CFG_STROBE_POL] ? sync_in[7] : !sync_in[7];
   assign torch_act  = config_r[CFG_TORCH_POL] ? sync_in[8] : !sync_in[8];
   assign tx_act     = enable_r[EN_TX] && (config_r[CFG_TX_POL] ? sync_in[9] : !sync_in[9]);
   assign tx_rise_ev = tx_act && !tx_prev_r;
   assign tx_fall_ev = !tx_act && tx_prev_r;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         tx_prev_r <= 1'b0;
      end else if (ce) begin
         tx_prev_r <= tx_act;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event and fault flags
   logic [7:0] flag_ev;
   logic       fault_ev;
   logic       tx_lock_ev;
   always_comb begin
      flag_ev              = 8'h00;
      flag_ev[FLG_TX]      = tx_rise_ev;
      flag_ev[FLG_NTC]     = cond_s[6] && enable_r[EN_NTC];
      flag_ev[FLG_INPUT_SUPPLY_MONITOR]    = cond_s[5] && config_r[CFG_INPUT_SUPPLY_MONITOR_EN];
      flag_ev[FLG_UNDERVOLTAGE_LOCKOUT]    = cond_s[4];
      flag_ev[FLG_OVP]     = cond_s[3];
      flag_ev[FLG_SHORT]   = cond_s[2];
      flag_ev[FLG_TSD]     = cond_s[1];
      flag_ev[FLG_TIMEOUT] = cond_s[0];
   end
   assign fault_ev   = |(flag_ev & FAULT_MASK);
   assign tx_lock_ev = tx_rise_ev && !config_r[CFG_TX_LEVEL] &&
                       (mode == MODE_TORCH || mode == MODE_INDICATOR);

   // Set wins over the read clear, so a standing condition re-flags at once
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         flags_r <= FLAGS_RST;
      end else if (ce) begin
         flags_r <= (rd_flags ? 8'h00 : flags_r) | flag_ev;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         fault_lock_r <= 1'b0;
      end else if (ce) begin
         fault_lock_r <= (fault_lock_r && !rd_flags) || fault_ev;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         tx_lock_r <= 1'b0;
      end else if (ce) begin
         tx_lock_r <= (tx_lock_r && !rd_flags) || tx_lock_ev;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Requested LED state and its delay
   logic             want_now;
   logic             want_r;
   logic             wait_stop_r;
   logic             main_load;
   logic [CNT_W-1:0] main_val;
   logic             wait_set;
   logic             main_done;
   always_comb begin
      want_now = 1'b0;
      if (!fault_lock_r) begin
         unique case (mode)
            MODE_STANDBY:   want_now = 1'b0;
            MODE_INDICATOR: want_now = torch_act;
            MODE_TORCH:     want_now = enable_r[EN_TORCH] ? torch_act : 1'b1;
            MODE_FLASH:     want_now = enable_r[EN_STROBE] ? strobe_act : 1'b1;
         endcase
      end
   end

   always_comb begin
      main_load = 1'b0;
      main_val  = CNT_W'(1);
      wait_set  = 1'b0;
      if (want_now != want_r) begin
         if (wr_seen_r && !fault_lock_r) begin
            if (want_now) begin
               main_load = 1'b1;
               main_val  = WR_ON_CYC_P;
            end else begin
               wait_set = 1'b1;
            end
         end else if (fault_lock_r || mode == MODE_STANDBY || mode == MODE_INDICATOR) begin
            main_load = 1'b1;
         end else if (mode == MODE_FLASH) begin
            main_load = 1'b1;
            main_val  = want_now ? STB_ON_CYC_P : CNT_W'(STB_OFF_CYC);
         end else begin
            main_load = 1'b1;
            main_val  = want_now ? TRC_ON_CYC_P : CNT_W'(TRC_OFF_CYC);
         end
      end else if (wait_stop_r && serial_stop) begin
         main_load = 1'b1;
         main_val  = STOP_OFF_CYC_P;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         want_r      <= 1'b0;
         wait_stop_r <= 1'b0;
      end else if (ce) begin
         want_r      <= want_now;
         wait_stop_r <= wait_set || (wait_stop_r && !main_load);
      end
   end

   delay_timer #(.W(CNT_W)) u_main_dly (
      .clk_sys  (clk_sys),
      .reset_n  (reset_n),
      .ce       (ce),
      .load     (main_load),
      .load_val (main_val),
      .done     (main_done)
   );

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         led_on <= 1'b0;
      end else if (ce && main_done) begin
         led_on <= want_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit-sync current reduction
   logic             tx_target_r;
   logic             tx_load;
   logic [CNT_W-1:0] tx_val;
   logic             tx_done;
   logic             timed_out;
   assign timed_out = flags_r[FLG_TIMEOUT] || flag_ev[FLG_TIMEOUT];
   assign tx_load   = tx_rise_ev || (tx_fall_ev && !timed_out);
   assign tx_val    = tx_rise_ev ? CNT_W'(TX_DOWN_CYC) : CNT_W'(TX_UP_CYC);

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         tx_target_r <= 1'b0;
      end else if (ce && tx_load) begin
         tx_target_r <= tx_rise_ev;
      end
   end

   delay_timer #(.W(CNT_W)) u_tx_dly (
      .clk_sys  (clk_sys),
      .reset_n  (reset_n),
      .ce       (ce),
      .load     (tx_load),
      .load_val (tx_val),
      .done     (tx_done)
   );

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         tx_reduced <= 1'b0;
      end else if (ce && tx_done) begin
         tx_reduced <= tx_target_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Drive level towards the current source
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         led_drive     <= DRV_OFF;
         fault_inhibit <= 1'b0;
         mode_locked   <= 1'b0;
      end else if (ce) begin
         fault_inhibit <= fault_lock_r;
         mode_locked   <= tx_lock_r;
         if (!led_on) begin
            led_drive <= DRV_OFF;
         end else begin
            unique case (mode)
               MODE_STANDBY:   led_drive <= DRV_OFF;
               MODE_INDICATOR: led_drive <= DRV_INDICATOR;
               MODE_TORCH:     led_drive <= DRV_TORCH;
               MODE_FLASH: begin
                  if (!tx_reduced) begin
                     led_drive <= DRV_FLASH;
                  end else begin
                     led_drive <= config_r[CFG_TX_LEVEL] ? DRV_TORCH : DRV_OFF;
                  end
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks; a cycle counter per timer ties each timer expiry to the delay it was given
   logic [CNT_W-1:0] main_age_r;
   logic [CNT_W-1:0] main_len_r;
   logic [CNT_W-1:0] tx_age_r;
   logic [CNT_W-1:0] tx_len_r;
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         main_age_r <= '0;
         main_len_r <= '0;
         tx_age_r   <= '0;
         tx_len_r   <= '0;
      end else if (ce) begin
         main_age_r <= main_load ? CNT_W'(1) : main_age_r + 1'b1;
         tx_age_r   <= tx_load ? CNT_W'(1) : tx_age_r + 1'b1;
         if (main_load) begin
            main_len_r <= main_val;
         end
         if (tx_load) begin
            tx_len_r <= tx_val;
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n || !ce);

   sequence tx_start_s;
      tx_rise_ev ##1 !tx_load;
   endsequence
   sequence stop_off_s;
      wait_stop_r && serial_stop && (want_now == want_r);
   endsequence

   standby_off_a: assert property ((mode == MODE_STANDBY) |-> !want_now)
      else $error("standby requests LED current");
   torch_nopin_a: assert property ((mode == MODE_TORCH) && !enable_r[EN_TORCH] && !fault_lock_r
                                   |-> want_now)
      else $error("torch without pin enable not requested");
   flash_nopin_a: assert property ((mode == MODE_FLASH) && !enable_r[EN_STROBE] && !fault_lock_r
                                   |-> want_now)
      else $error("flash without pin enable not requested");
   write_on_a: assert property (wr_seen_r && !fault_lock_r && want_now && !want_r
                                |=> main_len_r == WR_ON_CYC_P)
      else $error("write turn-on delay wrong");
   stop_off_a: assert property (stop_off_s |=> main_len_r == STOP_OFF_CYC_P)
      else $error("stop turn-off delay wrong");
   strobe_edge_a: assert property (mode == MODE_FLASH && !wr_seen_r && !fault_lock_r
                                   && (want_now != want_r)
                                   |=> main_len_r == ($past(want_now) ? STB_ON_CYC_P : CNT_W'(STB_OFF_CYC)))
      else $error("strobe delay wrong");
   torch_edge_a: assert property (mode == MODE_TORCH && !wr_seen_r && !fault_lock_r
                                  && (want_now != want_r)
                                  |=> main_len_r == ($past(want_now) ? TRC_ON_CYC_P : CNT_W'(TRC_OFF_CYC)))
      else $error("torch delay wrong");
   main_expiry_a: assert property (main_done |-> main_age_r == main_len_r + 1'b1)
      else $error("main delay expired at wrong cycle");
   tx_down_a: assert property (tx_start_s |-> tx_len_r == CNT_W'(TX_DOWN_CYC))
      else $error("transmit reduce delay wrong");
   tx_expiry_a: assert property (tx_done |-> tx_age_r == tx_len_r + 1'b1
                                 ##1 tx_reduced == $past(tx_target_r))
      else $error("transmit delay expired at wrong cycle");
   tx_timeout_a: assert property (tx_fall_ev && timed_out |-> !tx_load)
      else $error("current restored after time-out");
   flag_set_a: assert property (cond_s[4] || cond_s[1]
                                |=> (flags_r[FLG_UNDERVOLTAGE_LOCKOUT] || !$past(cond_s[4])) && (flags_r[FLG_TSD] || !$past(cond_s[1])))
      else $error("fault condition not flagged");
   flag_read_a: assert property (rd_flags |=> reg_rdata == $past(flags_r) &&
                                 flags_r == $past(flag_ev))
      else $error("flag read-clear wrong");
   fault_hold_a: assert property (fault_ev |=> fault_lock_r && !want_now)
      else $error("fault did not inhibit");
   tx_flag_a: assert property (tx_rise_ev |=> flags_r[FLG_TX])
      else $error("transmit event not flagged");
   mode_lock_a: assert property (tx_lock_r && !rd_flags && !tx_lock_ev ##0 wr_en_acc
                                 |=> enable_r[1:0] == $past(enable_r[1:0]))
      else $error("mode changed while locked");
endmodule : flash_led_mode_flag_control
`default_nettype wire

// *** rtl/pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         reset_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic meta_r;
      logic q_r;
      // Each bit has its own two flops; the port is only wired from the second, so q has one driver per bit
      always_ff @(posedge clk_sys) begin
         if (!reset_n) begin
            meta_r <= 1'b0;
            q_r    <= 1'b0;
         end else if (ce) begin
            meta_r <= d[i];
            q_r    <= meta_r;
         end
      end
      assign q[i] = q_r;
   end
endmodule : pin_sync
`default_nettype wire

// *** testbench/host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input  wire logic       clk_sys,
   input  wire logic [7:0] reg_rdata,
   output var  logic       reg_wr_stb,
   output var  logic       reg_rd_stb,
   output var  logic [7:0] reg_addr,
   output var  logic [7:0] reg_wdata,
   output var  logic       serial_stop,
   output var  logic       strobe_pin,
   output var  logic       torch_pin,
   output var  logic       tx_pin
);
   initial begin
      {reg_wr_stb, reg_rd_stb, serial_stop, strobe_pin, torch_pin, tx_pin} = 6'h00;
      {reg_addr, reg_wdata} = 16'h0000;
   end
   ////////////////////////////////////////
   // Flag read-back is the only way a fault lock is released
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
      @(posedge clk_sys);
      reg_wr_stb <= w;
      reg_rd_stb <= !w;
      reg_addr   <= a;
      reg_wdata  <= wd;
      @(posedge clk_sys);
      {reg_wr_stb, reg_rd_stb} <= 2'b00;
      // Stale data would hide a late capture
      reg_wdata  <= ~wd;
      @(posedge clk_sys);
      rd = reg_rdata;
   endtask : acc
   task automatic stop();
      @(posedge clk_sys);
      serial_stop <= 1'b1;
      @(posedge clk_sys);
      serial_stop <= 1'b0;
   endtask : stop
   task automatic pins(input logic s, input logic t, input logic x);
      @(posedge clk_sys);
      {strobe_pin, torch_pin, tx_pin} <= {s, t, x};
   endtask : pins
endmodule : host_model
`default_nettype wire

// *** testbench/test_flash_led_mode_flag_control.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_flash_led_mode_flag_control
   import flash_ctl_pkg::*;
;
   localparam int WR = 20;
   localparam int STOP = 10;
   localparam int STB = 15;
   localparam int TRC = 12;
   logic            clk_sys, reset_n, ce, led_on, tx_reduced, fault_inhibit, mode_locked;
   logic [6:0]      cond;
   logic [7:0]      reg_rdata, d;
   logic [1:0]      led_drive;
   logic [31:0]     r;
   wire logic       reg_wr_stb, reg_rd_stb, serial_stop, strobe_pin, torch_pin, tx_pin;
   wire logic [7:0] reg_addr, reg_wdata;
   int              seed, err_total, num_checks;
   flash_led_mode_flag_control #(.WR_ON_CYC_P(CNT_W'(WR)), .STOP_OFF_CYC_P(CNT_W'(STOP)),
      .STB_ON_CYC_P(CNT_W'(STB)), .TRC_ON_CYC_P(CNT_W'(TRC))) dut (
      .clk_sys, .reset_n, .ce, .reg_wr_stb, .reg_rd_stb, .reg_addr, .reg_wdata, .serial_stop,
      .reg_rdata, .strobe_pin, .torch_pin, .tx_pin, .thermistor_check_trip(cond[6]),
      .input_supply_monitor_act(cond[5]), .undervoltage_lockout_trip(cond[4]),
      .overvoltage_guard_trip(cond[3]), .led_short_det(cond[2]), .thermal_shutdown_det(cond[1]),
      .flash_timer_expired(cond[0]), .led_on, .led_drive, .tx_reduced, .fault_inhibit, .mode_locked);
   host_model host (.clk_sys, .reg_rdata, .reg_wr_stb, .reg_rd_stb, .reg_addr, .reg_wdata,
      .serial_stop, .strobe_pin, .torch_pin, .tx_pin);
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////
   task automatic chk(input logic ok, input string m);
      num_checks++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask : chk
   function automatic logic pick(input int s);
      return s == 0 ? led_on : (s == 1 ? tx_reduced : mode_locked);
   endfunction : pick
   function automatic logic [7:0] flag_exp(input int i);
      return 8'h01 << i;
   endfunction : flag_exp
   // Settled cycles until the output takes v; earlier than n is as wrong as late
   task automatic meas(input int s, input logic v, input int n, input string m);
      int c;
      c = 0;
      while (pick(s) !== v && c < n + 10) begin
         @(negedge clk_sys);
         c++;
      end
      chk(c >= n && c < n + 10, m);
   endtask : meas
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      host.acc(1'b1, a, v, d);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      host.acc(1'b0, a, 8'h00, d);
   endtask : rd
   task automatic off();
      wr(REG_ENABLE, 8'h00);
      host.stop();
      meas(0, 1'b0, STOP, "ramp down after stop");
   endtask : off
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   initial begin
      #400000;
      err_total++;
      print_verdict();
   end
   ////////////////////////////////////////
   initial begin
      seed = 32'h5143;
      reset_n = 1'b0;
      ce = 1'b1;
      cond = 7'h00;
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd(REG_CONFIG);
      chk(d === CONFIG_RST, "config reset");
      r = $random(seed);
      wr(8'h80 | r[7:0], r[15:8]);
      wr(REG_FLAGS, r[23:16]);
      rd(8'h80 | r[7:0]);
      chk(d === 8'h00, "unmapped read");
      rd(REG_FLAGS);
      chk(d === FLAGS_RST, "flags reset");
      $display("test reset done");
      for (int m = 2; m < 4; m++) begin
         wr(REG_ENABLE, 8'(m));
         meas(0, 1'b1, WR, "ramp up after write");
         @(negedge clk_sys);
         chk(led_drive === 2'(m), "serial mode drive");
         off();
      end
      for (int i = 0; i < 2; i++) begin
         wr(REG_ENABLE, i ? 8'h12 : 8'h23);
         host.pins(i == 0, i == 1, 1'b0);
         meas(0, 1'b1, i ? TRC : STB, "pin ramp up");
         host.pins(1'b0, 1'b0, 1'b0);
         meas(0, 1'b0, i ? TRC_OFF_CYC : STB_OFF_CYC, "pin ramp down");
      end
      wr(REG_ENABLE, 8'h01);
      host.pins(1'b0, 1'b1, 1'b0);
      meas(0, 1'b1, 0, "indicator on");
      @(negedge clk_sys);
      chk(led_drive === DRV_INDICATOR, "indicator drive");
      host.pins(1'b0, 1'b0, 1'b0);
      meas(0, 1'b0, 0, "indicator off");
      $display("test modes done");
      wr(REG_ENABLE, 8'h43);
      meas(0, 1'b1, WR, "flash on");
      host.pins(1'b0, 1'b0, 1'b1);
      meas(1, 1'b1, TX_DOWN_CYC, "tx reduce");
      @(negedge clk_sys);
      chk(led_drive === DRV_TORCH, "reduced drive level");
      host.pins(1'b0, 1'b0, 1'b0);
      meas(1, 1'b0, TX_UP_CYC, "tx restore");
      off();
      rd(REG_FLAGS);
      chk(d[FLG_TX] === 1'b1, "tx flag");
      wr(REG_CONFIG, CONFIG_RST & 8'hF7);
      wr(REG_ENABLE, 8'h42);
      meas(0, 1'b1, WR, "torch on");
      host.pins(1'b0, 1'b0, 1'b1);
      meas(2, 1'b1, 0, "mode lock");
      host.pins(1'b0, 1'b0, 1'b0);
      wr(REG_ENABLE, 8'h40);
      host.stop();
      repeat (STOP + 20) @(negedge clk_sys);
      chk(led_on === 1'b1, "locked mode held");
      rd(REG_FLAGS);
      meas(2, 1'b0, 0, "lock released");
      off();
      $display("test tx done");
      wr(REG_CONFIG, CONFIG_RST | 8'h04);
      wr(REG_ENABLE, 8'h80);
      for (int i = 0; i < 7; i++) begin
         cond <= 7'(flag_exp(i));
         repeat (6) @(posedge clk_sys);
         rd(REG_FLAGS);
         chk(d === flag_exp(i), "flag set");
         chk(fault_inhibit === FAULT_MASK[i], "inhibit");
         rd(REG_FLAGS);
         chk(d === flag_exp(i), "flag set again");
         cond <= 7'h00;
         repeat (6) @(posedge clk_sys);
         rd(REG_FLAGS);
         rd(REG_FLAGS);
         chk(d === 8'h00, "flag cleared");
         @(negedge clk_sys);
         chk(fault_inhibit === 1'b0, "inhibit cleared");
      end
      $display("test flags done");
      print_verdict();
   end
endmodule : test_flash_led_mode_flag_control
`default_nettype wire
